/* rtl/vsb_core_map.sv */
// Address unit of the processor core: program counter with vector table, interrupt
// acknowledge sequencer, upward-growing hardware stack and register bank selection.
// Assumes all inputs are synchronous to i_ref_clk and strobes last one cycle.
`timescale 1ns/1ns
`default_nettype none
`include "vsb_regs.svh"

module vsb_core_map
   import vsb_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Program counter control
   input wire logic i_pc_step,
   input wire logic i_pc_load,
   input wire vsb_paddr_t i_pc_load_addr,
   // Interrupts: bit 0 supply, 1..4 basic, 5..8 comm, 9..12 analog, 13 pin, 14 sleep
   input wire logic [14:0] i_irq_pend,
   input wire logic i_irq_ack,
   // Stack
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic [7:0] i_push_data,
   input wire logic i_sp_load,
   input wire vsb_daddr_t i_sp_load_val,
   // Register access
   input wire logic i_bank_extend_flag,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   // Program counter status
   output vsb_paddr_t o_pc_q,
   output logic o_pc_user_q,
   output logic o_pc_in_flash_q,
   // Interrupt status
   output logic o_irq_busy_q,
   output logic [3:0] o_irq_src_q,
   output logic o_vec_enter_q,
   // Stack status
   output vsb_daddr_t o_sp_q,
   output logic o_stack_wrap_q,
   output logic [7:0] o_pop_data_q,
   output logic o_pop_valid_q,
   // Decoded register access
   output logic o_reg_bank_q,
   output logic o_reg_shared_q,
   output logic [8:0] o_reg_index_q,
   output logic o_reg_wr_q,
   output logic o_reg_rd_q
);

   // Highest implemented flash address; a smaller variant lowers it.
   parameter vsb_paddr_t FLASH_TOP = `VSB_PC_MAX;

   // ========================================================================
   // Helpers

   // Lowest index wins: the supply monitor has the highest priority.
   function automatic logic [3:0] first_pending(input logic [14:0] p);
      first_pending = `VSB_IRQ_NONE;
      for (int k = `VSB_NUM_IRQ - 1; k >= 0; k--) begin
         if (p[k]) begin
            first_pending = 4'(k);
         end
      end
   endfunction

   // Sources sit in consecutive four-byte slots after the reset vector.
   function automatic vsb_paddr_t vector_of(input logic [3:0] src);
      vector_of = `VSB_VEC_SUPPLY + {8'h00, src, 2'b00};
   endfunction

   // 14-bit wrap keeps the counter inside the program space.
   function automatic vsb_paddr_t pc_next(input vsb_paddr_t pc);
      pc_next = (pc == `VSB_PC_MAX) ? `VSB_VEC_RESET : pc + `VSB_PC_ONE;
   endfunction

   // ========================================================================
   // Interrupt acknowledge sequencer

   vsb_ack_state_t state_q;
   vsb_ack_state_t state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [3:0] src_d;
   vsb_paddr_t vec_q;
   vsb_paddr_t vec_d;
   logic busy_d;
   logic enter_d;
   logic take_ack;
   logic pc_frozen;
   logic [3:0] pick;

   // An acknowledge is taken only from idle with a source pending; a late or
   // spurious acknowledge is dropped rather than queued, so software must
   // acknowledge again once the busy flag has fallen.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      vec_d = vec_q;
      src_d = o_irq_src_q;
      enter_d = 1'b0;
      take_ack = 1'b0;
      pick = first_pending(i_irq_pend);
      case (state_q)
         VSB_IDLE: begin
            if (i_irq_ack && (pick != `VSB_IRQ_NONE)) begin
               take_ack = 1'b1;
               state_d = VSB_WAIT;
               cnt_d = `VSB_CNT_ONE;
               src_d = pick;
               vec_d = vector_of(pick);
            end
         end
         VSB_WAIT: begin
            if (cnt_q == `VSB_ACK_CYCLES) begin
               state_d = VSB_IDLE;
               enter_d = 1'b1;
            end else begin
               cnt_d = cnt_q + `VSB_CNT_ONE;
            end
         end
         default: begin
            state_d = VSB_IDLE;
         end
      endcase
      busy_d = (state_d == VSB_WAIT);
      // The counter is frozen against jumps from the acknowledge cycle until the
      // vector lands, so a stray step cannot shift the entry point.
      pc_frozen = take_ack || (state_q == VSB_WAIT);
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q <= VSB_IDLE;
         cnt_q <= 4'h0;
         vec_q <= `VSB_VEC_RESET;
         o_irq_src_q <= `VSB_IRQ_NONE;
         o_irq_busy_q <= 1'b0;
         o_vec_enter_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         vec_q <= vec_d;
         o_irq_src_q <= src_d;
         o_irq_busy_q <= busy_d;
         o_vec_enter_q <= enter_d;
      end
   end

   // ========================================================================
   // Program counter

   vsb_paddr_t pc_d;
   logic user_d;
   logic in_flash_d;

   // The vector wins over a jump, and a jump wins over a step.
   always_comb begin
      pc_d = o_pc_q;
      if (enter_d) begin
         pc_d = vec_q;
      end else if (!pc_frozen && i_pc_load) begin
         pc_d = i_pc_load_addr;
      end else if (!pc_frozen && i_pc_step) begin
         pc_d = pc_next(o_pc_q);
      end
      // The flags follow the next value so that they line up with the counter.
      user_d = (pc_d >= `VSB_USER_START);
      in_flash_d = (pc_d <= FLASH_TOP);
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_pc_q <= `VSB_VEC_RESET;
         o_pc_user_q <= 1'b0;
         o_pc_in_flash_q <= 1'b1;
      end else begin
         o_pc_q <= pc_d;
         o_pc_user_q <= user_d;
         o_pc_in_flash_q <= in_flash_d;
      end
   end

   // ========================================================================
   // Hardware stack

   // The pointer wraps freely in both directions; a push from the top location
   // lands on address zero and only the one-cycle wrap pulse records it.
   vsb_daddr_t sp_d;
   logic wrap_d;
   logic do_push;
   logic do_pop;

   // A push and a pop in one cycle cancel; neither touches memory.
   always_comb begin
      do_push = i_push && !i_pop && !i_sp_load;
      do_pop = i_pop && !i_push && !i_sp_load;
      sp_d = o_sp_q;
      wrap_d = 1'b0;
      if (i_sp_load) begin
         sp_d = i_sp_load_val;
      end else if (do_push) begin
         sp_d = o_sp_q + `VSB_SP_ONE;
         wrap_d = (o_sp_q == `VSB_SP_TOP);
      end else if (do_pop) begin
         sp_d = o_sp_q - `VSB_SP_ONE;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_sp_q <= `VSB_SP_BOTTOM;
         o_stack_wrap_q <= 1'b0;
         o_pop_valid_q <= 1'b0;
      end else begin
         o_sp_q <= sp_d;
         o_stack_wrap_q <= wrap_d;
         o_pop_valid_q <= do_pop;
      end
   end

   // Push writes at the pointer; pop reads the word below it.
   vsb_stack_ram u_stack_ram (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_we(do_push),
      .i_waddr(o_sp_q),
      .i_wdata(i_push_data),
      .i_re(do_pop),
      .i_raddr(sp_d),
      .o_rdata_q(o_pop_data_q)
   );

   // ========================================================================
   // Register bank selection

   // Writes to reserved addresses or bits are passed on unchecked; software keeps
   // them clear.
   vsb_bank_decode u_bank_decode (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_bank_extend_flag(i_bank_extend_flag),
      .i_reg_addr(i_reg_addr),
      .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd),
      .o_bank_q(o_reg_bank_q),
      .o_shared_q(o_reg_shared_q),
      .o_index_q(o_reg_index_q),
      .o_wr_q(o_reg_wr_q),
      .o_rd_q(o_reg_rd_q)
   );

endmodule

`default_nettype wire

/* rtl/vsb_regs.svh */
// Named constants for the vector, stack and bank address unit.
// Assumes a 14-bit program address, an 8-bit data RAM address and 8-bit register addresses.
`ifndef VSB_REGS_SVH
`define VSB_REGS_SVH

// ==========================================================================
// Program memory map
`define VSB_VEC_RESET 14'h0000
`define VSB_VEC_SUPPLY 14'h0004
`define VSB_VEC_DIG_FIRST 14'h0008
`define VSB_VEC_DIG_LAST 14'h0024
`define VSB_VEC_ANA_FIRST 14'h0028
`define VSB_VEC_ANA_LAST 14'h0034
`define VSB_VEC_GPIO 14'h0038
`define VSB_VEC_SLEEP 14'h003C
`define VSB_USER_START 14'h0040
`define VSB_PC_MAX 14'h3FFF
`define VSB_PC_ONE 14'h0001

// ==========================================================================
// Interrupt sources and acknowledge latency
`define VSB_NUM_IRQ 15
`define VSB_IRQ_NONE 4'hF
`define VSB_ACK_CYCLES 4'hD
`define VSB_CNT_ONE 4'h1

// ==========================================================================
// Data RAM stack
`define VSB_SP_BOTTOM 8'h00
`define VSB_SP_TOP 8'hFF
`define VSB_SP_ONE 8'h01

// ==========================================================================
// Register banks
`define VSB_SHARED_LO 8'h71
`define VSB_SHARED_HI 8'h9F

`endif

/* rtl/vsb_pkg.sv */
// Types shared by the vector, stack and bank address unit.
// Assumes the constants header is included by each user.
package vsb_pkg;

   typedef enum logic [0:0] {
      VSB_IDLE,
      VSB_WAIT
   } vsb_ack_state_t;

   typedef logic [13:0] vsb_paddr_t;
   typedef logic [7:0] vsb_daddr_t;

endpackage

/* rtl/vsb_stack_ram.sv */
// 256 by 8 stack memory with one write port and a registered read port.
// Assumes the caller never reads and writes the same word in one cycle.
`timescale 1ns/1ns
`default_nettype none
`include "vsb_regs.svh"

module vsb_stack_ram
   import vsb_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Write port
   input wire logic i_we,
   input wire vsb_daddr_t i_waddr,
   input wire logic [7:0] i_wdata,
   // Read port
   input wire logic i_re,
   input wire vsb_daddr_t i_raddr,
   output logic [7:0] o_rdata_q
);

   logic [7:0] mem [0:255];
   logic [7:0] rdata_d;

   always_comb begin
      rdata_d = o_rdata_q;
      if (i_re) begin
         rdata_d = mem[i_raddr];
      end
   end

   // The array has no reset: stack contents are undefined until pushed.
   always_ff @(posedge i_ref_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rdata_q <= 8'h00;
      end else begin
         o_rdata_q <= rdata_d;
      end
   end

endmodule

`default_nettype wire

/* rtl/vsb_bank_decode.sv */
// Register bank decoder: turns an 8-bit register address and the bank flag into a
// 9-bit register index. Shared window addresses always map into bank zero.
// Assumes the access strobes are one cycle long and synchronous.
`timescale 1ns/1ns
`default_nettype none
`include "vsb_regs.svh"

module vsb_bank_decode
   import vsb_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Access request
   input wire logic i_bank_extend_flag,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   // Decoded access
   output logic o_bank_q,
   output logic o_shared_q,
   output logic [8:0] o_index_q,
   output logic o_wr_q,
   output logic o_rd_q
);

   function automatic logic in_shared(input logic [7:0] a);
      in_shared = (a >= `VSB_SHARED_LO) && (a <= `VSB_SHARED_HI);
   endfunction

   logic bank_d;
   logic shared_d;
   logic [8:0] index_d;

   always_comb begin
      shared_d = in_shared(i_reg_addr);
      bank_d = shared_d ? 1'b0 : i_bank_extend_flag;
      index_d = {bank_d, i_reg_addr};
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_bank_q <= 1'b0;
         o_shared_q <= 1'b0;
         o_index_q <= 9'h000;
         o_wr_q <= 1'b0;
         o_rd_q <= 1'b0;
      end else begin
         o_bank_q <= bank_d;
         o_shared_q <= shared_d;
         o_index_q <= index_d;
         o_wr_q <= i_reg_wr;
         o_rd_q <= i_reg_rd;
      end
   end

endmodule

`default_nettype wire

/* verification/vsb_core_map_sva.sv */
// Concurrent checks for the vector, stack and bank address unit.
// Assumes it is bound to vsb_core_map and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module vsb_core_map_sva
   import vsb_pkg::*;
#(
   parameter vsb_paddr_t FLASH_TOP = 14'h3FFF
)
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Requests
   input wire logic i_pc_step,
   input wire logic i_pc_load,
   input wire logic [14:0] i_irq_pend,
   input wire logic i_irq_ack,
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic i_sp_load,
   input wire logic i_bank_extend_flag,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   // Results
   input wire vsb_paddr_t o_pc_q,
   input wire logic o_pc_user_q,
   input wire logic o_pc_in_flash_q,
   input wire logic o_irq_busy_q,
   input wire logic [3:0] o_irq_src_q,
   input wire logic o_vec_enter_q,
   input wire vsb_daddr_t o_sp_q,
   input wire logic o_stack_wrap_q,
   input wire logic o_pop_valid_q,
   input wire logic o_reg_bank_q,
   input wire logic o_reg_shared_q,
   input wire logic [8:0] o_reg_index_q,
   input wire logic o_reg_wr_q,
   input wire logic o_reg_rd_q
);
   // ==========================================================================
   // Helpers
   logic win;
   logic push_only;
   assign win = (i_reg_addr >= 8'h71) && (i_reg_addr <= 8'h9F);
   assign push_only = i_push && !i_pop && !i_sp_load;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   // ==========================================================================
   // Interrupt entry
   sequence s_ack;
      i_irq_ack && !o_irq_busy_q && (i_irq_pend != 15'h0000);
   endsequence
   sequence s_wait13;
      o_irq_busy_q[*8] ##1 o_irq_busy_q[*5];
   endsequence
   property p_irq_latency;
      s_ack |=> s_wait13 ##1 (!o_irq_busy_q && o_vec_enter_q);
   endproperty
   a_irq_latency: assert property (p_irq_latency)
      else $error("vector entry not 13 cycles after acknowledge");
   property p_vec_addr;
      o_vec_enter_q |-> o_pc_q == 14'h0004 + {8'h00, o_irq_src_q, 2'b00};
   endproperty
   a_vec_addr: assert property (p_vec_addr)
      else $error("vector address does not match source");

   // ==========================================================================
   // Program counter
   property p_pc_step;
      i_pc_step && !i_pc_load && !o_irq_busy_q && !i_irq_ack |=>
         o_pc_q == $past(o_pc_q) + 14'h0001;
   endproperty
   a_pc_step: assert property (p_pc_step)
      else $error("program counter step wrong");
   property p_user;
      o_pc_user_q == (o_pc_q >= 14'h0040);
   endproperty
   a_user: assert property (p_user)
      else $error("user space flag wrong");
   property p_flash;
      o_pc_in_flash_q == (o_pc_q <= FLASH_TOP);
   endproperty
   a_flash: assert property (p_flash)
      else $error("flash range flag wrong");

   // ==========================================================================
   // Stack
   property p_push;
      push_only && o_sp_q != 8'hFF |=> o_sp_q == $past(o_sp_q) + 8'h01 && !o_stack_wrap_q;
   endproperty
   a_push: assert property (p_push)
      else $error("push did not move stack up");
   property p_wrap;
      push_only && o_sp_q == 8'hFF |=> o_sp_q == 8'h00 && o_stack_wrap_q;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("push at top did not wrap");
   property p_pop;
      i_pop && !i_push && !i_sp_load |=> o_sp_q == $past(o_sp_q) - 8'h01 && o_pop_valid_q;
   endproperty
   a_pop: assert property (p_pop)
      else $error("pop did not move stack down");

   // ==========================================================================
   // Register banks
   property p_reg_map;
      !$past(i_reset) |-> o_reg_index_q == {$past(i_bank_extend_flag && !win), $past(i_reg_addr)}
         && o_reg_shared_q == $past(win) && o_reg_bank_q == o_reg_index_q[8]
         && o_reg_wr_q == $past(i_reg_wr) && o_reg_rd_q == $past(i_reg_rd);
   endproperty
   a_reg_map: assert property (p_reg_map)
      else $error("register decode wrong");
endmodule

bind vsb_core_map vsb_core_map_sva #(.FLASH_TOP(FLASH_TOP)) u_sva (.*);

`default_nettype wire

/* verification/vsb_core_map_tb.sv */
// Self-checking bench for the vector, stack and bank address unit.
// Assumes the checker is bound to the design; the bench drives every input itself.
`timescale 1ns/1ns
`default_nettype none

module vsb_core_map_tb;
   import vsb_pkg::*;
   // A smaller flash top exercises the variant where flash ends below the space.
   localparam vsb_paddr_t FLASH_LIM = 14'h1FFF;
   logic i_ref_clk = 1'b0, i_reset = 1'b1, i_pc_step = 1'b0, i_pc_load = 1'b0;
   logic i_irq_ack = 1'b0, i_push = 1'b0, i_pop = 1'b0, i_sp_load = 1'b0;
   logic i_bank_extend_flag = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic [14:0] i_irq_pend = 15'h0000;
   logic [7:0] i_push_data = 8'h00, i_reg_addr = 8'h00;
   vsb_paddr_t i_pc_load_addr = 14'h0000, o_pc_q;
   vsb_daddr_t i_sp_load_val = 8'h00, o_sp_q;
   logic o_pc_user_q, o_pc_in_flash_q, o_irq_busy_q, o_vec_enter_q, o_stack_wrap_q;
   logic o_pop_valid_q, o_reg_bank_q, o_reg_shared_q, o_reg_wr_q, o_reg_rd_q;
   logic [3:0] o_irq_src_q;
   logic [7:0] o_pop_data_q;
   logic [8:0] o_reg_index_q;
   logic [7:0] ra [4] = '{8'h70, 8'h71, 8'h9F, 8'hA0};
   int fail_count = 0, num_checks = 0;

   vsb_core_map #(.FLASH_TOP(FLASH_LIM)) dut (
      .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_pc_step(i_pc_step),
      .i_pc_load(i_pc_load), .i_pc_load_addr(i_pc_load_addr), .i_irq_pend(i_irq_pend),
      .i_irq_ack(i_irq_ack), .i_push(i_push), .i_pop(i_pop), .i_push_data(i_push_data),
      .i_sp_load(i_sp_load), .i_sp_load_val(i_sp_load_val),
      .i_bank_extend_flag(i_bank_extend_flag), .i_reg_addr(i_reg_addr),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_pc_q(o_pc_q), .o_pc_user_q(o_pc_user_q),
      .o_pc_in_flash_q(o_pc_in_flash_q), .o_irq_busy_q(o_irq_busy_q),
      .o_irq_src_q(o_irq_src_q), .o_vec_enter_q(o_vec_enter_q), .o_sp_q(o_sp_q),
      .o_stack_wrap_q(o_stack_wrap_q), .o_pop_data_q(o_pop_data_q),
      .o_pop_valid_q(o_pop_valid_q), .o_reg_bank_q(o_reg_bank_q),
      .o_reg_shared_q(o_reg_shared_q), .o_reg_index_q(o_reg_index_q),
      .o_reg_wr_q(o_reg_wr_q), .o_reg_rd_q(o_reg_rd_q)
   );

   initial forever #5 i_ref_clk = ~i_ref_clk;

   // ==========================================================================
   // Common tasks
   task cyc;
      @(posedge i_ref_clk);
   endtask
   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task final_report;
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task pc_op(input logic ld, input logic st, input vsb_paddr_t a);
      cyc;
      i_pc_load <= ld;
      i_pc_step <= st;
      i_pc_load_addr <= a;
      cyc;
      i_pc_load <= 1'b0;
      i_pc_step <= 1'b0;
      #1;
   endtask
   task sop(input logic pu, input logic po, input logic ld, input logic [7:0] v);
      cyc;
      i_push <= pu;
      i_pop <= po;
      i_sp_load <= ld;
      i_sp_load_val <= v;
      i_push_data <= v;
      cyc;
      i_push <= 1'b0;
      i_pop <= 1'b0;
      i_sp_load <= 1'b0;
      #1;
   endtask

   // ==========================================================================
   // Scenarios
   task t_reset;
      cyc;
      i_reset <= 1'b1;
      repeat (16) cyc;
      i_reset <= 1'b0;
      cyc;
      #1;
      chk("pc", 16'h0000, o_pc_q);
      chk("sp", 16'h0000, o_sp_q);
      chk("source", 16'h000F, o_irq_src_q);
      chk("in flash", 16'h0001, o_pc_in_flash_q);
      $display("test reset done");
   endtask
   task t_vectors;
      int n;
      // Each pass also sets every higher line, so the lowest index must win.
      for (int k = 0; k < 15; k++) begin
         cyc;
         i_irq_pend <= 15'h7FFF << k;
         i_irq_ack <= 1'b1;
         cyc;
         i_irq_ack <= 1'b0;
         n = 0;
         do begin
            cyc;
            #1;
            n++;
         end while (o_vec_enter_q !== 1'b1 && n < 20);
         chk("latency", 16'h000D, 16'(n));
         if (n == 20)
            final_report;
         chk("vector", 16'(4 + 4 * k), o_pc_q);
         chk("source", 16'(k), o_irq_src_q);
         chk("user", 16'h0000, o_pc_user_q);
         chk("busy", 16'h0000, o_irq_busy_q);
      end
      cyc;
      i_irq_pend <= 15'h0000;
      $display("test vectors done");
   endtask
   task t_pc;
      pc_op(1'b1, 1'b0, 14'h003F);
      chk("user", 16'h0000, o_pc_user_q);
      pc_op(1'b0, 1'b1, 14'h0000);
      chk("pc", 16'h0040, o_pc_q);
      chk("user", 16'h0001, o_pc_user_q);
      pc_op(1'b1, 1'b0, FLASH_LIM);
      chk("in flash", 16'h0001, o_pc_in_flash_q);
      pc_op(1'b0, 1'b1, 14'h0000);
      chk("in flash", 16'h0000, o_pc_in_flash_q);
      pc_op(1'b1, 1'b0, 14'h3FFF);
      pc_op(1'b0, 1'b1, 14'h0000);
      chk("pc", 16'h0000, o_pc_q);
      $display("test pc done");
   endtask
   task t_stack;
      sop(1'b0, 1'b0, 1'b1, 8'hFE);
      chk("sp", 16'h00FE, o_sp_q);
      sop(1'b1, 1'b0, 1'b0, 8'h5A);
      chk("sp", 16'h00FF, o_sp_q);
      sop(1'b1, 1'b0, 1'b0, 8'hA5);
      chk("sp", 16'h0000, o_sp_q);
      chk("wrap", 16'h0001, o_stack_wrap_q);
      sop(1'b1, 1'b1, 1'b0, 8'h33);
      chk("sp", 16'h0000, o_sp_q);
      sop(1'b0, 1'b1, 1'b0, 8'h00);
      chk("sp", 16'h00FF, o_sp_q);
      chk("pop data", 16'h00A5, o_pop_data_q);
      chk("pop valid", 16'h0001, o_pop_valid_q);
      sop(1'b0, 1'b1, 1'b0, 8'h00);
      chk("pop data", 16'h005A, o_pop_data_q);
      $display("test stack done");
   endtask
   task t_regs;
      logic fl;
      logic sh;
      for (int i = 0; i < 8; i++) begin
         fl = i[2];
         sh = (ra[i % 4] >= 8'h71) && (ra[i % 4] <= 8'h9F);
         cyc;
         i_bank_extend_flag <= fl;
         i_reg_addr <= ra[i % 4];
         i_reg_wr <= !i[0]; // Writes stay on the probed map addresses.
         i_reg_rd <= i[0];
         cyc;
         #1;
         chk("index", 16'({fl & !sh, ra[i % 4]}), o_reg_index_q);
         chk("shared", 16'(sh), o_reg_shared_q);
         chk("write strobe", 16'(!i[0]), o_reg_wr_q);
         chk("read strobe", 16'(i[0]), o_reg_rd_q);
         chk("bank", 16'(fl & !sh), o_reg_bank_q);
      end
      cyc;
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b0;
      $display("test regs done");
   endtask

   initial begin
      t_reset;
      t_vectors;
      t_pc;
      t_stack;
      t_reset;
      t_regs;
      final_report;
   end
endmodule

`default_nettype wire
